//--- design/flow_mode_pkg.sv
// Purpose: constants for the controller mode register set
// Assumes: single clock, synchronous active-high reset
// Notes:   register indices are local choices, words are 32 bits
package flow_mode_pkg;
   // register indices on the process-data port
   localparam logic [3:0]  IDX_GAS_TABLE    = 4'h0;
   localparam logic [3:0]  IDX_INLET_TEMP   = 4'h1;
   localparam logic [3:0]  IDX_VALVE_DRIVE  = 4'h2;
   localparam logic [3:0]  IDX_BOARD_SERIAL = 4'h3;
   localparam logic [3:0]  IDX_FLOW_CEILING = 4'h4;
   localparam logic [3:0]  IDX_PRESSURE     = 4'h5;
   localparam logic [3:0]  IDX_PRESS_TARGET = 4'h6;
   localparam logic [3:0]  IDX_MODE_SELECT  = 4'h7;
   localparam logic [3:0]  IDX_VALVE_BUFFER = 4'h8;
   // gas table limit
   localparam logic [15:0] GAS_TABLE_COUNT  = 16'h000A;
   // valve and set point scale, value 100 is full opening
   localparam logic [31:0] FULL_SCALE       = 32'h0000_0064;
   localparam logic [31:0] ZERO_SCALE       = 32'h0000_0000;
   // reset values
   localparam logic [15:0] RESET_GAS_TABLE  = 16'h0000;
   localparam logic [31:0] RESET_WORD       = 32'h0000_0000;
   // mode selector encodings
   localparam logic [15:0] MODE_AUTO        = 16'h0000;
   localparam logic [15:0] MODE_DIGITAL     = 16'h0001;
   localparam logic [15:0] MODE_ANALOG      = 16'h0002;
   localparam logic [15:0] MODE_PRESSURE    = 16'h0005;
   localparam logic [15:0] MODE_BACK_PRESS  = 16'h0006;
   localparam logic [15:0] MODE_VALVE_DIR   = 16'h000A;
   localparam logic [15:0] MODE_SP_ZERO     = 16'h0014;
   localparam logic [15:0] MODE_SP_FULL     = 16'h0015;
   localparam logic [15:0] MODE_VALVE_SHUT  = 16'h0016;
   localparam logic [15:0] MODE_VALVE_OPEN  = 16'h0017;
   localparam logic [15:0] RESET_MODE       = MODE_ANALOG;
   // set point source
   typedef enum logic [1:0] {SRC_ANALOG, SRC_DIGITAL, SRC_FORCED} sp_source_t;
   // regulation kind
   typedef enum logic [1:0] {REG_FLOW, REG_PRESSURE, REG_BACK_PRESS, REG_NONE} reg_kind_t;
endpackage : flow_mode_pkg

//--- design/flow_ctrl_mode_registers.sv
// Purpose: controller mode register set behind the process-data port
// Assumes: one-cycle write strobe with index, read data registered
// Notes:   readings are live inputs; board serial is a parameter
// Notes on behaviour
// - gas table index picks one of ten sets
// - valve register reads the applied control value
// - mode 10: written valve value applies immediately
// - other modes: value buffered, applied entering mode 10
// - valve value is percent, zero to 100
// - pressure target effective only in modes 0, 1
// - auto mode: analog default, digital write switches
// - mode 1: set point only from digital
// - mode 2: set point from analog input
// - mode 5 pressure, mode 6 back pressure regulation
// - mode 10: no regulation, valve from register
// - mode 20 zero set point, 21 full scale
// - mode 22: no regulation, valve closed
// - mode 23: no regulation, valve open
// - read-only 32-bit board serial number
`timescale 1ns/10ps
module flow_ctrl_mode_registers #(
   parameter logic [31:0] BOARD_SERIAL_ID = 32'h1234_5678 // arbitrary value
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // process-data port
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   input  wire logic [3:0]  reg_index,
   input  wire logic [31:0] wr_data,
   output logic      [31:0] rd_data,
   output logic             rd_valid,
   output logic             wr_refused,
   // digital set point arrival (flow or pressure)
   input  wire logic        digital_sp_write,
   // live readings and regulator
   input  wire logic [31:0] inlet_temp_in,
   input  wire logic [31:0] pressure_in,
   input  wire logic [31:0] flow_ceiling_in,
   input  wire logic [31:0] regulator_valve_in,
   // control outputs
   output logic      [15:0] gas_table_sel,
   output logic      [31:0] valve_drive_out,
   output logic             regulation_on,
   output logic      [1:0]  regulation_kind,
   output logic      [1:0]  sp_source,
   output logic      [31:0] forced_sp,
   output logic             pressure_target_on,
   output logic      [31:0] pressure_target_out
);

   logic [15:0] gas_table_q;
   logic [15:0] mode_q;
   logic        auto_digital_q;
   logic [31:0] valve_active_q;
   logic [31:0] valve_buffer_q;
   logic [31:0] press_target_q;
   logic        mode_ok;
   logic        valve_ok;
   logic        gas_ok;
   logic        wr_mode;
   logic        wr_valve;
   logic        entering_direct;
   logic        sel_gas;
   logic        sel_valve;
   logic        sel_mode;
   logic        sel_press;
   logic        regulation_on_d;
   logic [1:0]  regulation_kind_d;
   logic [1:0]  sp_source_d;
   logic [31:0] forced_sp_d;
   logic [31:0] valve_drive_d;
   logic        pressure_target_on_d;
   logic        wr_refused_d;
   logic [31:0] rd_data_d;

   // legal mode encodings
   always_comb begin
      unique case (wr_data[15:0])
         flow_mode_pkg::MODE_AUTO,
         flow_mode_pkg::MODE_DIGITAL,
         flow_mode_pkg::MODE_ANALOG,
         flow_mode_pkg::MODE_PRESSURE,
         flow_mode_pkg::MODE_BACK_PRESS,
         flow_mode_pkg::MODE_VALVE_DIR,
         flow_mode_pkg::MODE_SP_ZERO,
         flow_mode_pkg::MODE_SP_FULL,
         flow_mode_pkg::MODE_VALVE_SHUT,
         flow_mode_pkg::MODE_VALVE_OPEN: mode_ok = 1'b1;
         default: mode_ok = 1'b0;
      endcase
   end

   assign valve_ok        = wr_data <= flow_mode_pkg::FULL_SCALE;
   assign gas_ok          = wr_data[31:16] == 16'h0000
                            && wr_data[15:0] < flow_mode_pkg::GAS_TABLE_COUNT;
   // index decode shared by the write paths
   assign sel_gas         = reg_index == flow_mode_pkg::IDX_GAS_TABLE;
   assign sel_valve       = reg_index == flow_mode_pkg::IDX_VALVE_DRIVE;
   assign sel_mode        = reg_index == flow_mode_pkg::IDX_MODE_SELECT;
   assign sel_press       = reg_index == flow_mode_pkg::IDX_PRESS_TARGET;
   // a refused value must leave every register untouched
   assign wr_mode         = wr_en && sel_mode && mode_ok;
   assign wr_valve        = wr_en && sel_valve && valve_ok;
   // rewriting mode 10 while in it must not reload the active value from the buffer
   assign entering_direct = wr_mode && wr_data[15:0] == flow_mode_pkg::MODE_VALVE_DIR
                            && mode_q != flow_mode_pkg::MODE_VALVE_DIR;

   // gas table index
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         gas_table_q <= flow_mode_pkg::RESET_GAS_TABLE;
      end else if (wr_en && sel_gas && gas_ok) begin
         gas_table_q <= wr_data[15:0];
      end
   end

   // mode selector
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mode_q <= flow_mode_pkg::RESET_MODE;
      end else if (wr_mode) begin
         mode_q <= wr_data[15:0];
      end
   end

   // auto mode latches to digital once a digital set point arrives
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         auto_digital_q <= 1'b0;
      end else if (wr_mode) begin
         auto_digital_q <= 1'b0;
      end else if (mode_q == flow_mode_pkg::MODE_AUTO && digital_sp_write) begin
         auto_digital_q <= 1'b1;
      end
   end

   // valve holding buffer and active value
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         valve_buffer_q <= flow_mode_pkg::RESET_WORD;
      end else if (wr_valve) begin
         valve_buffer_q <= wr_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         valve_active_q <= flow_mode_pkg::RESET_WORD;
      end else if (wr_valve && mode_q == flow_mode_pkg::MODE_VALVE_DIR) begin
         valve_active_q <= wr_data;
      end else if (entering_direct) begin
         valve_active_q <= valve_buffer_q;
      end
   end

   // pressure target
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         press_target_q <= flow_mode_pkg::RESET_WORD;
      end else if (wr_en && sel_press) begin
         press_target_q <= wr_data;
      end
   end

   // decoded control outputs, next values from the active mode
   // outputs lag a mode write by two cycles: register, then decode
   always_comb begin
      regulation_on_d      = 1'b1;
      regulation_kind_d    = flow_mode_pkg::REG_FLOW;
      sp_source_d          = flow_mode_pkg::SRC_ANALOG;
      forced_sp_d          = flow_mode_pkg::ZERO_SCALE;
      valve_drive_d        = regulator_valve_in;
      pressure_target_on_d = 1'b0;
      unique case (mode_q)
         flow_mode_pkg::MODE_AUTO: begin
            sp_source_d          = auto_digital_q ? flow_mode_pkg::SRC_DIGITAL
                                                  : flow_mode_pkg::SRC_ANALOG;
            pressure_target_on_d = 1'b1;
         end
         flow_mode_pkg::MODE_DIGITAL: begin
            sp_source_d          = flow_mode_pkg::SRC_DIGITAL;
            pressure_target_on_d = 1'b1;
         end
         flow_mode_pkg::MODE_ANALOG: begin
            sp_source_d = flow_mode_pkg::SRC_ANALOG;
         end
         flow_mode_pkg::MODE_PRESSURE: begin
            regulation_kind_d = flow_mode_pkg::REG_PRESSURE;
         end
         flow_mode_pkg::MODE_BACK_PRESS: begin
            regulation_kind_d = flow_mode_pkg::REG_BACK_PRESS;
         end
         flow_mode_pkg::MODE_VALVE_DIR: begin
            regulation_on_d   = 1'b0;
            regulation_kind_d = flow_mode_pkg::REG_NONE;
            valve_drive_d     = valve_active_q;
         end
         flow_mode_pkg::MODE_SP_ZERO: begin
            sp_source_d = flow_mode_pkg::SRC_FORCED;
            forced_sp_d = flow_mode_pkg::ZERO_SCALE;
         end
         flow_mode_pkg::MODE_SP_FULL: begin
            sp_source_d = flow_mode_pkg::SRC_FORCED;
            forced_sp_d = flow_mode_pkg::FULL_SCALE;
         end
         flow_mode_pkg::MODE_VALVE_SHUT: begin
            regulation_on_d   = 1'b0;
            regulation_kind_d = flow_mode_pkg::REG_NONE;
            valve_drive_d     = flow_mode_pkg::ZERO_SCALE;
         end
         flow_mode_pkg::MODE_VALVE_OPEN: begin
            regulation_on_d   = 1'b0;
            regulation_kind_d = flow_mode_pkg::REG_NONE;
            valve_drive_d     = flow_mode_pkg::FULL_SCALE;
         end
         default: begin
            // unreachable: only listed codes are ever stored
            regulation_on_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         regulation_on      <= 1'b1;
         regulation_kind    <= flow_mode_pkg::REG_FLOW;
         sp_source          <= flow_mode_pkg::SRC_ANALOG;
         forced_sp          <= flow_mode_pkg::ZERO_SCALE;
         valve_drive_out    <= flow_mode_pkg::ZERO_SCALE;
         pressure_target_on <= 1'b0;
      end else begin
         regulation_on      <= regulation_on_d;
         regulation_kind    <= regulation_kind_d;
         sp_source          <= sp_source_d;
         forced_sp          <= forced_sp_d;
         valve_drive_out    <= valve_drive_d;
         pressure_target_on <= pressure_target_on_d;
      end
   end

   // applied gas table index
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         gas_table_sel <= flow_mode_pkg::RESET_GAS_TABLE;
      end else begin
         gas_table_sel <= gas_table_q;
      end
   end

   // pressure target toward the regulator
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pressure_target_out <= flow_mode_pkg::RESET_WORD;
      end else begin
         pressure_target_out <= press_target_q;
      end
   end

   // write refusal: bad value, read-only index or unused index, one-cycle pulse
   always_comb begin
      wr_refused_d = 1'b0;
      if (wr_en) begin
         unique case (reg_index)
            flow_mode_pkg::IDX_GAS_TABLE:    wr_refused_d = !gas_ok;
            flow_mode_pkg::IDX_VALVE_DRIVE:  wr_refused_d = !valve_ok;
            flow_mode_pkg::IDX_MODE_SELECT:  wr_refused_d = !mode_ok;
            flow_mode_pkg::IDX_PRESS_TARGET: wr_refused_d = 1'b0;
            flow_mode_pkg::IDX_INLET_TEMP,
            flow_mode_pkg::IDX_BOARD_SERIAL,
            flow_mode_pkg::IDX_FLOW_CEILING,
            flow_mode_pkg::IDX_PRESSURE,
            flow_mode_pkg::IDX_VALVE_BUFFER: wr_refused_d = 1'b1;
            default:                         wr_refused_d = 1'b1;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wr_refused <= 1'b0;
      end else begin
         wr_refused <= wr_refused_d;
      end
   end

   // read word selection; rd_data holds between reads
   always_comb begin
      rd_data_d = rd_data;
      if (rd_en) begin
         unique case (reg_index)
            flow_mode_pkg::IDX_GAS_TABLE:    rd_data_d = {16'h0000, gas_table_q};
            flow_mode_pkg::IDX_INLET_TEMP:   rd_data_d = inlet_temp_in;
            flow_mode_pkg::IDX_VALVE_DRIVE:  rd_data_d = valve_drive_out;
            flow_mode_pkg::IDX_BOARD_SERIAL: rd_data_d = BOARD_SERIAL_ID;
            flow_mode_pkg::IDX_FLOW_CEILING: rd_data_d = flow_ceiling_in;
            flow_mode_pkg::IDX_PRESSURE:     rd_data_d = pressure_in;
            flow_mode_pkg::IDX_PRESS_TARGET: rd_data_d = press_target_q;
            flow_mode_pkg::IDX_MODE_SELECT:  rd_data_d = {16'h0000, mode_q};
            flow_mode_pkg::IDX_VALVE_BUFFER: rd_data_d = valve_buffer_q;
            default:                         rd_data_d = flow_mode_pkg::RESET_WORD;
         endcase
      end
   end

   // read path register; rd_valid marks the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rd_data  <= flow_mode_pkg::RESET_WORD;
         rd_valid <= 1'b0;
      end else begin
         rd_data  <= rd_data_d;
         rd_valid <= rd_en;
      end
   end

endmodule : flow_ctrl_mode_registers

//--- verif/plant_model.sv
// Purpose: far-side stand-in giving live readings and regulator output
// Assumes: readings held steady so read-back values are exact
// Notes:   values are plain test figures
`timescale 1ns/10ps
module plant_model #(
   parameter logic [31:0] TEMP  = 32'h0000_0017,
   parameter logic [31:0] PRESS = 32'h0000_0102,
   parameter logic [31:0] CEIL  = 32'h0000_0300,
   parameter logic [31:0] REGV  = 32'h0000_0021
) (
   // readings toward the register set
   output logic [31:0] inlet_temp_in,
   output logic [31:0] pressure_in,
   output logic [31:0] flow_ceiling_in,
   output logic [31:0] regulator_valve_in
);
   assign inlet_temp_in      = TEMP;
   assign pressure_in        = PRESS;
   assign flow_ceiling_in    = CEIL;
   assign regulator_valve_in = REGV;
endmodule : plant_model

//--- verif/flow_mode_monitor.sv
// Purpose: port-level checks of the controller mode register set
// Assumes: decoded outputs settle two cycles after a mode write
// Notes:   bound to every instance of the register set
`timescale 1ns/10ps
module flow_mode_monitor #(
   parameter logic [31:0] BOARD_SERIAL_ID = 32'h1234_5678
) (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        reset,
   // process-data port
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [3:0]  reg_index,
   input wire logic [31:0] wr_data,
   input wire logic [31:0] rd_data,
   input wire logic        rd_valid,
   input wire logic        wr_refused,
   // control outputs
   input wire logic        regulation_on,
   input wire logic [1:0]  sp_source,
   input wire logic [31:0] forced_sp,
   input wire logic [31:0] valve_drive_out
);
   logic        mw;
   logic [15:0] m;
   assign mw = wr_en && reg_index == 4'h7 && wr_data[31:16] == 16'h0000;
   assign m  = wr_data[15:0];
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   serial_read_a: assert property (rd_en && reg_index == 4'h3 |=>
      rd_valid && rd_data == BOARD_SERIAL_ID) else $error("serial read wrong");
   bad_mode_a: assert property (mw && (m == 16'h0003 || m > 16'h0017) |=>
      wr_refused) else $error("unlisted mode accepted");
   gas_limit_a: assert property (wr_en && reg_index == 4'h0 &&
      wr_data >= 32'h0000_000A |=> wr_refused) else $error("gas index over limit");
   valve_limit_a: assert property (wr_en && reg_index == 4'h2 &&
      wr_data > 32'h0000_0064 |=> wr_refused) else $error("valve over full scale");
   direct_valve_a: assert property (mw && m == 16'h000A |-> ##2
      !regulation_on) else $error("regulation kept in direct mode");
   valve_shut_a: assert property (mw && m == 16'h0016 |-> ##2
      !regulation_on && valve_drive_out == 32'h0000_0000) else $error("valve not shut");
   valve_open_a: assert property (mw && m == 16'h0017 |-> ##2
      !regulation_on && valve_drive_out == 32'h0000_0064) else $error("valve not open");
   sp_forced_a: assert property (mw && m == 16'h0015 |-> ##2
      sp_source == 2'h2 && forced_sp == 32'h0000_0064) else $error("set point not full");
   cover property (mw && m == 16'h000A);
   cover property (rd_valid);
   cover property (wr_refused);
endmodule : flow_mode_monitor
bind flow_ctrl_mode_registers flow_mode_monitor #(.BOARD_SERIAL_ID(BOARD_SERIAL_ID)) mon_i (
   .sys_clk, .reset, .wr_en, .rd_en, .reg_index, .wr_data, .rd_data, .rd_valid,
   .wr_refused, .regulation_on, .sp_source, .forced_sp, .valve_drive_out);

//--- verif/test_flow_ctrl_mode_registers.sv
// Purpose: directed test of the controller mode register set
// Assumes: inputs change 1 ns after the rising edge
// Notes:   readings come from the plant model
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin mismatches++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module test_flow_ctrl_mode_registers;
   localparam logic [31:0] SERIAL = 32'h0BAD_F00D; // arbitrary value
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic [3:0]  reg_index = 4'h0;
   logic [31:0] wr_data = 32'h0000_0000;
   logic        digital_sp_write = 1'b0;
   logic [31:0] rd_data, inlet_temp_in, pressure_in, flow_ceiling_in, regulator_valve_in;
   logic [31:0] valve_drive_out, forced_sp, pressure_target_out;
   logic [15:0] gas_table_sel;
   logic [1:0]  regulation_kind, sp_source;
   logic        rd_valid, wr_refused, regulation_on, pressure_target_on;
   int          mismatches = 0;
   int          checks = 0;
   plant_model plant_model_i (.inlet_temp_in, .pressure_in, .flow_ceiling_in,
      .regulator_valve_in);
   flow_ctrl_mode_registers #(.BOARD_SERIAL_ID(SERIAL)) flow_ctrl_mode_registers_i (
      .sys_clk, .reset, .wr_en, .rd_en, .reg_index, .wr_data, .rd_data, .rd_valid,
      .wr_refused, .digital_sp_write, .inlet_temp_in, .pressure_in, .flow_ceiling_in,
      .regulator_valve_in, .gas_table_sel, .valve_drive_out, .regulation_on,
      .regulation_kind, .sp_source, .forced_sp, .pressure_target_on, .pressure_target_out);
   always #5 sys_clk = ~sys_clk;
   task automatic tick;
      @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic wr(input logic [3:0] i, input logic [31:0] d, input logic r);
      tick;
      wr_en = 1'b1;
      reg_index = i;
      wr_data = d;
      tick;
      wr_en = 1'b0;
      `CHK("refused", r, wr_refused)
   endtask : wr
   task automatic rd(input logic [3:0] i, input logic [31:0] e);
      tick;
      rd_en = 1'b1;
      reg_index = i;
      tick;
      rd_en = 1'b0;
      `CHK("rd valid", 1'b1, rd_valid)
      `CHK("rd data", e, rd_data)
   endtask : rd
   task automatic set_mode(input logic [15:0] md);
      wr(4'h7, {16'h0000, md}, 1'b0);
      tick;
   endtask : set_mode
   task automatic report_and_stop;
      if (mismatches == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (3000) @(posedge sys_clk);
      mismatches++;
      report_and_stop;
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      `CHK("sp source", 2'h0, sp_source)
      rd(4'h7, 32'h0000_0002);
      wr(4'h3, 32'h0000_0001, 1'b1);
      rd(4'h3, SERIAL);
      wr(4'h0, 32'h0000_0009, 1'b0);
      wr(4'h0, 32'h0000_000A, 1'b1);
      `CHK("gas table", 16'h0009, gas_table_sel)
      rd(4'h1, inlet_temp_in);
      wr(4'h2, 32'h0000_0065, 1'b1);
      wr(4'h2, 32'h0000_0028, 1'b0);
      rd(4'h8, 32'h0000_0028);
      rd(4'h2, regulator_valve_in);
      set_mode(16'h000A);
      `CHK("valve", 32'h0000_0028, valve_drive_out)
      `CHK("regulating", 1'b0, regulation_on)
      wr(4'h2, 32'h0000_0064, 1'b0);
      tick;
      `CHK("valve", 32'h0000_0064, valve_drive_out)
      rd(4'h2, 32'h0000_0064);
      set_mode(16'h0014);
      `CHK("forced sp", 32'h0000_0000, forced_sp)
      `CHK("sp source", 2'h2, sp_source)
      set_mode(16'h0015);
      `CHK("forced sp", 32'h0000_0064, forced_sp)
      set_mode(16'h0016);
      `CHK("valve", 32'h0000_0000, valve_drive_out)
      `CHK("regulating", 1'b0, regulation_on)
      set_mode(16'h0017);
      `CHK("valve", 32'h0000_0064, valve_drive_out)
      set_mode(16'h0005);
      `CHK("reg kind", 2'h1, regulation_kind)
      `CHK("press on", 1'b0, pressure_target_on)
      `CHK("regulating", 1'b1, regulation_on)
      set_mode(16'h0006);
      `CHK("reg kind", 2'h2, regulation_kind)
      set_mode(16'h0001);
      `CHK("sp source", 2'h1, sp_source)
      `CHK("press on", 1'b1, pressure_target_on)
      set_mode(16'h0000);
      `CHK("sp source", 2'h0, sp_source)
      wr(4'h6, 32'h0000_0032, 1'b0);
      rd(4'h6, 32'h0000_0032);
      `CHK("press target", 32'h0000_0032, pressure_target_out)
      wr(4'h7, 32'h0000_0003, 1'b1);
      rd(4'h7, 32'h0000_0000);
      tick;
      digital_sp_write = 1'b1;
      tick;
      digital_sp_write = 1'b0;
      tick;
      `CHK("sp source", 2'h1, sp_source)
      report_and_stop;
   end
endmodule : test_flow_ctrl_mode_registers
